/* rtl/srvio_in_select.sv */
/*
  Decoder of one input pin's function selector into the function vector.
  Assumes the pin level has already passed polarity and simulation.
*/
`timescale 1ns/100ps
module srvio_in_select
  import srvio_pkg::*;
(
  input  wire logic [15:0]   code,
  input  wire logic          level,
  output logic [FN_W-1:0]    assigned,
  output logic [FN_W-1:0]    fn_high,
  output logic [FN_W-1:0]    fn_low
);

  logic [15:0] code_m1;
  logic        single;

  assign code_m1 = code - 16'h0001;

  // ------------------------------------------------------------
  // code to function vector
  // ------------------------------------------------------------
  always_comb
  begin
    assigned = '0;
    single   = (code[14:0] & code_m1[14:0]) == 15'h0000;
    if (code[EXT_FLAG_BIT])
    begin
      if (single && code[14:12] == 3'b000)
        assigned = {code[11:0], {FN_STD_W{1'b0}}};
    end
    else if (single)
      assigned = {{FN_EXT_W{1'b0}}, code[14:0]};
  end

  assign fn_high = level ? assigned : '0;
  assign fn_low  = level ? '0 : assigned;

endmodule : srvio_in_select

/* rtl/srvio_mapper.sv */
/*
  Servo drive digital I/O function mapper: four inputs, two outputs,
  selectors, polarity masks, simulation and port status registers.
  Assumes synchronous pins and a single-cycle register port.
*/
`timescale 1ns/100ps

// Operation
// - one 16-bit selector per input 1..4, reset 0000 meaning no function
// - input codes 0001..0080 select enable through direction inversion
// - input codes 0100..4000 select indexes, quick stop, homing, activate
// - codes 8001..8010 select index bit 2 and gear-ratio multi signals
// - codes 8020..8100 select gain switch, current toggle, motor error
// - codes 8400 and 8800 select fast capture channels 1 and 2
// - pre-enable assigned without any enable input raises an alarm
// - output codes 0001..0010 select ready, error, reached, zero, brake
// - output codes 0020..0200 select speed, index, limits, enabled
// - output codes 0400..4000 and 8001 select home, torque, multi, SAFE_TORQUE_OFF
// - input polarity mask bit per input, set inverts, reset all ones
// - input simulation bit per input forces input active, reset zero
// - output simulation bit per output forces output active, reset zero
// - 16-bit output polarity mask sets active level, reset all ones
// - enable active passes selected control word, else control word 0x06
// - limit inputs normally closed; low level inhibits that direction
module srvio_mapper
  import srvio_pkg::*;
#(
  parameter int N_IN  = 4,
  parameter int N_OUT = 2
)
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire srvio_pkg::srvio_req_t reg_req,
  output logic [15:0]              reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic                digital_input_1,
  input  wire logic                digital_input_2,
  input  wire logic                digital_input_3,
  input  wire logic                digital_input_4,
  output logic                     digital_output_1,
  output logic                     digital_output_2,
  input  wire logic [15:0]         drive_status,
  input  wire logic [15:0]         din_control_word,
  output srvio_pkg::srvio_in_fn_t  in_functions,
  output logic [15:0]              control_word,
  output logic                     inhibit_positive,
  output logic                     inhibit_negative,
  output logic                     pre_enable_alarm,
  output logic                     capture_1_pulse,
  output logic                     capture_2_pulse
);
  import srvio_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0]       in_pol_reg;
  logic [15:0]       in_sim_reg;
  logic [15:0]       in_sel_reg [N_IN];
  logic [15:0]       out_pol_reg;
  logic [15:0]       out_sim_reg;
  logic [15:0]       out_sel_reg [N_OUT];
  logic [15:0]       in_state_reg;
  logic [15:0]       out_state_reg;
  logic [N_IN-1:0]   raw_in;
  logic [N_IN-1:0]   in_level;
  logic [FN_W-1:0]   asg_v [N_IN];
  logic [FN_W-1:0]   high_v [N_IN];
  logic [FN_W-1:0]   low_v [N_IN];
  logic [FN_W-1:0]   fn_assigned;
  logic [FN_W-1:0]   fn_active;
  logic [FN_W-1:0]   fn_low;
  logic [N_OUT-1:0]  out_level;
  logic [N_OUT-1:0]  out_pin;
  logic              cap1_prev_reg;
  logic              cap2_prev_reg;
  srvio_in_fn_t      fn_next;
  logic [15:0]       rdata_next;

  assign raw_in = {digital_input_4, digital_input_3,
                   digital_input_2, digital_input_1};

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      in_pol_reg  <= RST_IN_POL;
      in_sim_reg  <= RST_IN_SIM;
      out_pol_reg <= RST_OUT_POL;
      out_sim_reg <= RST_OUT_SIM;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_IN_POL:  in_pol_reg  <= reg_req.wdata;
        OFS_IN_SIM:  in_sim_reg  <= reg_req.wdata;
        OFS_OUT_POL: out_pol_reg <= reg_req.wdata;
        OFS_OUT_SIM: out_sim_reg <= reg_req.wdata;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < N_IN; i++)
        in_sel_reg[i] <= RST_IN_SEL;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_IN1_SEL: in_sel_reg[0] <= reg_req.wdata;
        OFS_IN2_SEL: in_sel_reg[1] <= reg_req.wdata;
        OFS_IN3_SEL: in_sel_reg[2] <= reg_req.wdata;
        OFS_IN4_SEL: in_sel_reg[3] <= reg_req.wdata;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      out_sel_reg[0] <= RST_OUT1_SEL;
      out_sel_reg[1] <= RST_OUT2_SEL;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_OUT1_SEL: out_sel_reg[0] <= reg_req.wdata;
        OFS_OUT2_SEL: out_sel_reg[1] <= reg_req.wdata;
        default:      ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // input path: polarity, simulation, decode
  // ------------------------------------------------------------
  // a set polarity bit inverts the pin; a simulation bit forces active
  assign in_level = (raw_in ^ in_pol_reg[N_IN-1:0])
                    | in_sim_reg[N_IN-1:0];

  for (genvar g = 0; g < N_IN; g++)
  begin : g_in
    srvio_in_select u_sel (
      .code     (in_sel_reg[g]),
      .level    (in_level[g]),
      .assigned (asg_v[g]),
      .fn_high  (high_v[g]),
      .fn_low   (low_v[g])
    );
  end

  always_comb
  begin
    fn_assigned = '0;
    fn_active   = '0;
    fn_low      = '0;
    for (int i = 0; i < N_IN; i++)
    begin
      fn_assigned = fn_assigned | asg_v[i];
      fn_active   = fn_active | high_v[i];
      fn_low      = fn_low | low_v[i];
    end
  end

  always_comb
  begin
    fn_next                = '0;
    fn_next.drive_enable   = fn_active[FN_ENABLE];
    fn_next.error_reset    = fn_active[FN_ERR_RST];
    fn_next.mode_control   = fn_active[FN_MODE];
    fn_next.speed_int_off  = fn_active[FN_KVI_OFF];
    fn_next.home_switch    = fn_active[FN_HOME];
    fn_next.dir_invert     = fn_active[FN_DIR_INV];
    fn_next.speed_index    = {fn_active[FN_SPD_IDX2],
                              fn_active[FN_SPD_IDX1],
                              fn_active[FN_SPD_IDX0]};
    fn_next.position_index = {fn_active[FN_POS_IDX2],
                              fn_active[FN_POS_IDX1],
                              fn_active[FN_POS_IDX0]};
    fn_next.quick_stop     = fn_active[FN_QSTOP];
    fn_next.start_homing   = fn_active[FN_HOMING];
    fn_next.activate_cmd   = fn_active[FN_ACTIVATE];
    fn_next.multi_func     = fn_active[FN_MULTI0 +: 3];
    fn_next.gain_switch    = fn_active[FN_GAIN0 +: 2];
    fn_next.max_current    = fn_active[FN_MAX_CUR];
    fn_next.motor_error    = fn_active[FN_MOTOR_ERR];
    fn_next.capture_1      = fn_active[FN_CAPT1];
    fn_next.capture_2      = fn_active[FN_CAPT2];
  end

  // ------------------------------------------------------------
  // registered function outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      in_functions     <= '0;
      control_word     <= CTRL_WORD_OFF;
      inhibit_positive <= 1'b0;
      inhibit_negative <= 1'b0;
      pre_enable_alarm <= 1'b0;
    end
    else
    begin
      in_functions     <= fn_next;
      control_word     <= fn_next.drive_enable ? din_control_word
                                               : CTRL_WORD_OFF;
      inhibit_positive <= fn_low[FN_POS_LIM];
      inhibit_negative <= fn_low[FN_NEG_LIM];
      pre_enable_alarm <= fn_assigned[FN_PRE_EN]
                          & ~fn_assigned[FN_ENABLE];
    end
  end

  // capture pulses mark the rising edge of each capture function
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cap1_prev_reg   <= 1'b0;
      cap2_prev_reg   <= 1'b0;
      capture_1_pulse <= 1'b0;
      capture_2_pulse <= 1'b0;
    end
    else
    begin
      cap1_prev_reg   <= fn_next.capture_1;
      cap2_prev_reg   <= fn_next.capture_2;
      capture_1_pulse <= fn_next.capture_1 & ~cap1_prev_reg;
      capture_2_pulse <= fn_next.capture_2 & ~cap2_prev_reg;
    end
  end

  // ------------------------------------------------------------
  // output path: select, simulation, polarity
  // ------------------------------------------------------------
  always_comb
  begin
    for (int k = 0; k < N_OUT; k++)
    begin
      if (out_sel_reg[k] == OUT_CODE_STO)
        out_level[k] = drive_status[EXT_FLAG_BIT];
      else if (out_sel_reg[k][EXT_FLAG_BIT])
        out_level[k] = 1'b0;
      else
        out_level[k] = |(out_sel_reg[k][14:0]
                         & drive_status[14:0]);
      out_level[k] = out_level[k] | out_sim_reg[k];
      // a clear polarity bit turns the output active low
      out_pin[k]   = out_pol_reg[k] ? out_level[k]
                                    : ~out_level[k];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      digital_output_1 <= ~RST_OUT_POL[0];
      digital_output_2 <= ~RST_OUT_POL[1];
    end
    else
    begin
      digital_output_1 <= out_pin[0];
      digital_output_2 <= out_pin[1];
    end
  end

  // ------------------------------------------------------------
  // port status
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      in_state_reg  <= RST_IN_STATE;
      out_state_reg <= RST_OUT_STATE;
    end
    else
    begin
      in_state_reg  <= {in_state_reg[15:N_IN], in_level};
      out_state_reg <= {out_state_reg[15:N_OUT], out_level};
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_comb
  begin
    case (reg_req.addr)
      OFS_IN_POL:    rdata_next = in_pol_reg;
      OFS_IN_SIM:    rdata_next = in_sim_reg;
      OFS_IN1_SEL:   rdata_next = in_sel_reg[0];
      OFS_IN2_SEL:   rdata_next = in_sel_reg[1];
      OFS_IN3_SEL:   rdata_next = in_sel_reg[2];
      OFS_IN4_SEL:   rdata_next = in_sel_reg[3];
      OFS_IN_STATE:  rdata_next = in_state_reg;
      OFS_OUT_POL:   rdata_next = out_pol_reg;
      OFS_OUT_SIM:   rdata_next = out_sim_reg;
      OFS_OUT1_SEL:  rdata_next = out_sel_reg[0];
      OFS_OUT2_SEL:  rdata_next = out_sel_reg[1];
      OFS_OUT_STATE: rdata_next = out_state_reg;
      default:       rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd)
        reg_rdata <= rdata_next;
    end
  end

endmodule : srvio_mapper

/* rtl/srvio_pkg.sv */
/*
  Shared constants and types of the servo I/O function mapper.
  Assumes a single clock domain and the object-dictionary register port.
*/
package srvio_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [15:0] OFS_IN_POL    = 16'h0810;
  localparam logic [15:0] OFS_IN_SIM    = 16'h0820;
  localparam logic [15:0] OFS_IN1_SEL   = 16'h0830;
  localparam logic [15:0] OFS_IN2_SEL   = 16'h0840;
  localparam logic [15:0] OFS_IN3_SEL   = 16'h0850;
  localparam logic [15:0] OFS_IN4_SEL   = 16'h0860;
  localparam logic [15:0] OFS_IN_STATE  = 16'h08a0;
  localparam logic [15:0] OFS_OUT_POL   = 16'h08d0;
  localparam logic [15:0] OFS_OUT_SIM   = 16'h08e0;
  localparam logic [15:0] OFS_OUT1_SEL  = 16'h08f0;
  localparam logic [15:0] OFS_OUT2_SEL  = 16'h0900;
  localparam logic [15:0] OFS_OUT_STATE = 16'h0940;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_IN_POL    = 16'hffff;
  localparam logic [15:0] RST_IN_SIM    = 16'h0000;
  localparam logic [15:0] RST_IN_SEL    = 16'h0000;
  localparam logic [15:0] RST_IN_STATE  = 16'h0000;
  localparam logic [15:0] RST_OUT_POL   = 16'hffff;
  localparam logic [15:0] RST_OUT_SIM   = 16'h0000;
  localparam logic [15:0] RST_OUT1_SEL  = 16'h0001;
  localparam logic [15:0] RST_OUT2_SEL  = 16'h0002;
  localparam logic [15:0] RST_OUT_STATE = 16'h000a;

  // ------------------------------------------------------------
  // function codes and vector layout
  // ------------------------------------------------------------
  localparam int          FN_STD_W      = 15;
  localparam int          FN_EXT_W      = 12;
  localparam int          FN_W          = FN_STD_W + FN_EXT_W;
  localparam int          EXT_FLAG_BIT  = 15;
  localparam logic [15:0] OUT_CODE_STO  = 16'h8001;
  localparam logic [15:0] CTRL_WORD_OFF = 16'h0006;

  // input function positions in the decoded vector
  localparam int FN_ENABLE    = 0;
  localparam int FN_ERR_RST   = 1;
  localparam int FN_MODE      = 2;
  localparam int FN_KVI_OFF   = 3;
  localparam int FN_POS_LIM   = 4;
  localparam int FN_NEG_LIM   = 5;
  localparam int FN_HOME      = 6;
  localparam int FN_DIR_INV   = 7;
  localparam int FN_SPD_IDX0  = 8;
  localparam int FN_SPD_IDX1  = 9;
  localparam int FN_POS_IDX0  = 10;
  localparam int FN_POS_IDX1  = 11;
  localparam int FN_QSTOP     = 12;
  localparam int FN_HOMING    = 13;
  localparam int FN_ACTIVATE  = 14;
  localparam int FN_SPD_IDX2  = 15;
  localparam int FN_POS_IDX2  = 16;
  localparam int FN_MULTI0    = 17;
  localparam int FN_GAIN0     = 20;
  localparam int FN_MAX_CUR   = 22;
  localparam int FN_MOTOR_ERR = 23;
  localparam int FN_PRE_EN    = 24;
  localparam int FN_CAPT1     = 25;
  localparam int FN_CAPT2     = 26;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       drive_enable;
    logic       error_reset;
    logic       mode_control;
    logic       speed_int_off;
    logic       dir_invert;
    logic       home_switch;
    logic [2:0] speed_index;
    logic [2:0] position_index;
    logic       quick_stop;
    logic       start_homing;
    logic       activate_cmd;
    logic [2:0] multi_func;
    logic [1:0] gain_switch;
    logic       max_current;
    logic       motor_error;
    logic       capture_1;
    logic       capture_2;
  } srvio_in_fn_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } srvio_req_t;

endpackage : srvio_pkg

/* tb/srvio_mapper_checker.sv */
/*
  Port assertions of the servo I/O function mapper.
  Assumes binding to srvio_mapper; input selectors shadowed from writes.
*/
`timescale 1ns/100ps
module srvio_mapper_checker
  import srvio_pkg::*;
#(
  parameter int N_IN  = 4,
  parameter int N_OUT = 2
)
(
  input wire logic                    clock,
  input wire logic                    rst,
  input wire srvio_pkg::srvio_req_t   reg_req,
  input wire logic [15:0]             reg_rdata,
  input wire logic                    reg_rvalid,
  input wire logic [15:0]             din_control_word,
  input wire srvio_pkg::srvio_in_fn_t in_functions,
  input wire logic [15:0]             control_word,
  input wire logic                    pre_enable_alarm,
  input wire logic                    capture_1_pulse,
  input wire logic                    capture_2_pulse
);
  logic [15:0] sel_reg [4];
  logic        any_pre;
  logic        any_en;
  logic        none_set;

  // ------------------------------------------------------------
  // shadow of the input selectors
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        sel_reg[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (reg_req.wr && reg_req.addr == OFS_IN1_SEL + 16'(i * 16))
          sel_reg[i] <= reg_req.wdata;
    end
  end

  always_comb
  begin
    any_pre  = 1'b0;
    any_en   = 1'b0;
    none_set = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      any_pre  = any_pre | (sel_reg[i] == 16'h8200);
      any_en   = any_en | (sel_reg[i] == 16'h0001);
      none_set = none_set & (sel_reg[i] == 16'h0000);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("read answer without a read");
  a_rdata_hold: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_enable_word: assert property (in_functions.drive_enable |->
    control_word == $past(din_control_word))
    else $error("control word not passed while enabled");
  a_idle_word: assert property (!in_functions.drive_enable |->
    control_word == CTRL_WORD_OFF)
    else $error("control word not 06 while disabled");
  a_capture_one: assert property (capture_1_pulse ==
    (in_functions.capture_1 && !$past(in_functions.capture_1)))
    else $error("capture 1 pulse not on rising edge");
  a_capture_two: assert property (capture_2_pulse ==
    (in_functions.capture_2 && !$past(in_functions.capture_2)))
    else $error("capture 2 pulse not on rising edge");
  a_alarm_cause: assert property (pre_enable_alarm ==
    $past(any_pre && !any_en))
    else $error("pre-enable alarm wrong");
  a_no_function: assert property ($past(none_set) |->
    in_functions == '0)
    else $error("function active with no selector set");
endmodule : srvio_mapper_checker

bind srvio_mapper srvio_mapper_checker #(.N_IN(N_IN), .N_OUT(N_OUT)) chk_u (
  .clock            (clock),
  .rst              (rst),
  .reg_req          (reg_req),
  .reg_rdata        (reg_rdata),
  .reg_rvalid       (reg_rvalid),
  .din_control_word (din_control_word),
  .in_functions     (in_functions),
  .control_word     (control_word),
  .pre_enable_alarm (pre_enable_alarm),
  .capture_1_pulse  (capture_1_pulse),
  .capture_2_pulse  (capture_2_pulse)
);

/* tb/srvio_mapper_tb.sv */
/*
  Self-checking bench of the servo I/O function mapper.
  Assumes the switch model on the pins and the bound checker.
*/
`timescale 1ns/100ps
module srvio_mapper_tb;
  import srvio_pkg::*;
  logic         clock            = 1'b0;
  logic         rst              = 1'b1;
  srvio_req_t   reg_req          = '0;
  logic [3:0]   contacts         = 4'hf;
  logic [15:0]  drive_status     = 16'h0000;
  logic [15:0]  din_control_word = 16'h000f;
  logic [15:0]  reg_rdata;
  logic         reg_rvalid;
  logic [1:0]   lamps;
  wire logic [3:0] din_pins;
  wire logic [1:0] dout_pins;
  srvio_in_fn_t in_functions;
  logic [15:0]  control_word;
  logic [1:0]   inhibit;
  logic         pre_enable_alarm;
  int           fails            = 0;
  int           total_checks     = 0;
  int           cycles           = 0;

  always #2 clock = ~clock;

  srvio_mapper dut_u (.clock(clock), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .digital_input_1(din_pins[0]), .digital_input_2(din_pins[1]),
    .digital_input_3(din_pins[2]), .digital_input_4(din_pins[3]),
    .digital_output_1(dout_pins[0]), .digital_output_2(dout_pins[1]),
    .drive_status(drive_status), .din_control_word(din_control_word),
    .in_functions(in_functions), .control_word(control_word),
    .inhibit_positive(inhibit[1]), .inhibit_negative(inhibit[0]),
    .pre_enable_alarm(pre_enable_alarm), .capture_1_pulse(),
    .capture_2_pulse());

  srvio_switch_model sw_u (.contacts(contacts),
    .digital_output_1(dout_pins[0]), .digital_output_2(dout_pins[1]),
    .digital_input_1(din_pins[0]), .digital_input_2(din_pins[1]),
    .digital_input_3(din_pins[2]), .digital_input_4(din_pins[3]),
    .lamps(lamps));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_req.addr  = a;
    reg_req.wdata = d;
    reg_req.wr    = 1'b1;
    tick(1);
    reg_req.wr = 1'b0;
    tick(1);
  endtask : wr

  task automatic rdv(input logic [15:0] a, input logic [15:0] e);
    reg_req.addr = a;
    reg_req.rd   = 1'b1;
    tick(1);
    reg_req.rd = 1'b0;
    chk("read answer", 24'h1, 24'(reg_rvalid));
    chk($sformatf("reg %h", a), 24'(e), 24'(reg_rdata));
    tick(1);
  endtask : rdv

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    logic [15:0] ofs [13] = '{OFS_IN_POL, OFS_IN_SIM, OFS_IN1_SEL,
      OFS_IN2_SEL, OFS_IN3_SEL, OFS_IN4_SEL, OFS_IN_STATE, OFS_OUT_POL,
      OFS_OUT_SIM, OFS_OUT1_SEL, OFS_OUT2_SEL, OFS_OUT_STATE, 16'h0870};
    logic [15:0] rv [13] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0001,
      16'h0002, 16'h0008, 16'h0000};
    for (int i = 0; i < 13; i++)
      rdv(ofs[i], rv[i]);
    wr(OFS_IN_STATE, 16'hffff);
    wr(OFS_OUT_STATE, 16'hffff);
    rdv(OFS_IN_STATE, 16'h0000);
    rdv(OFS_OUT_STATE, 16'h0008);
    $display("test reset values done");
  endtask : t_reset_values

  task automatic t_in_codes();
    logic [15:0] code [29] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
      16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000,
      16'h2000, 16'h4000, 16'h8001, 16'h8002, 16'h8004, 16'h8008, 16'h8010,
      16'h8020, 16'h8040, 16'h8080, 16'h8100, 16'h8400, 16'h8800, 16'h0010,
      16'h0020, 16'h8200, 16'h0003, 16'h9000};
    int pos [29] = '{23, 22, 21, 20, 18, 19, 15, 16, 12, 13, 11, 10, 9, 17,
      14, 6, 7, 8, 4, 5, 3, 2, 1, 0, 24, 24, 24, 24, 24};
    logic [15:0] sa;
    for (int i = 0; i < 29; i++)
    begin
      sa = OFS_IN1_SEL + 16'((i % 4) * 16);
      wr(sa, code[i]);
      contacts[i % 4] = 1'b0;
      tick(2);
      chk($sformatf("functions %h", code[i]), 24'(1) << pos[i],
        24'(in_functions));
      contacts = 4'hf;
      wr(sa, 16'h0000);
    end
    $display("test input codes done");
  endtask : t_in_codes

  task automatic t_enable();
    wr(OFS_IN1_SEL, 16'h0001);
    contacts[0] = 1'b0;
    tick(2);
    chk("word on", 24'(din_control_word), 24'(control_word));
    rdv(OFS_IN_STATE, 16'h0001);
    contacts[0] = 1'b1;
    tick(2);
    chk("word off", 24'h000006, 24'(control_word));
    wr(OFS_IN_POL, 16'hfffe);
    tick(1);
    chk("plain polarity", 24'h00000f, 24'(control_word));
    contacts[0] = 1'b0;
    wr(OFS_IN_SIM, 16'h0001);
    tick(1);
    chk("simulated in", 24'h00000f, 24'(control_word));
    wr(OFS_IN_POL, 16'hffff);
    wr(OFS_IN_SIM, 16'h0000);
    wr(OFS_IN1_SEL, 16'h0000);
    contacts = 4'hf;
    $display("test enable done");
  endtask : t_enable

  task automatic t_limits_alarm();
    wr(OFS_IN2_SEL, 16'h0010);
    wr(OFS_IN3_SEL, 16'h0020);
    chk("limits open", 24'h3, 24'(inhibit));
    contacts[1] = 1'b0;
    tick(2);
    chk("positive closed", 24'h1, 24'(inhibit));
    wr(OFS_IN4_SEL, 16'h8200);
    chk("alarm set", 24'h1, 24'(pre_enable_alarm));
    wr(OFS_IN1_SEL, 16'h0001);
    chk("alarm clear", 24'h0, 24'(pre_enable_alarm));
    $display("test limits and alarm done");
  endtask : t_limits_alarm

  task automatic t_outputs();
    logic [15:0] code;
    // an extended code other than safe torque off keeps output 2 idle
    wr(OFS_OUT2_SEL, 16'h8002);
    for (int n = 0; n < 16; n++)
    begin
      code = (n < 15) ? (16'h0001 << n) : 16'h8001;
      wr(OFS_OUT1_SEL, code);
      drive_status = 16'h0001 << n;
      tick(2);
      chk($sformatf("out on %h", code), 24'h1, 24'(lamps));
      drive_status = ~(16'h0001 << n);
      tick(2);
      chk($sformatf("out off %h", code), 24'h0, 24'(lamps));
    end
    drive_status = 16'h0000;
    wr(OFS_OUT_SIM, 16'h0002);
    tick(1);
    chk("simulated out", 24'h2, 24'(lamps));
    rdv(OFS_OUT_STATE, 16'h000a);
    wr(OFS_OUT_POL, 16'h0000);
    tick(1);
    chk("inverted out", 24'h1, 24'(lamps));
    $display("test outputs done");
  endtask : t_outputs

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end

  initial
  begin
    tick(8);
    rst = 1'b0;
    tick(1);
    t_reset_values();
    t_in_codes();
    t_enable();
    t_limits_alarm();
    t_outputs();
    results();
  end
endmodule : srvio_mapper_tb

/* tb/srvio_switch_model.sv */
/*
  Switch bank and lamp load standing on the mapper's pins.
  Assumes the bench sets contact levels just after a clock edge.
*/
`timescale 1ns/100ps
module srvio_switch_model
(
  input  wire logic [3:0] contacts,
  input  wire logic       digital_output_1,
  input  wire logic       digital_output_2,
  output logic            digital_input_1,
  output logic            digital_input_2,
  output logic            digital_input_3,
  output logic            digital_input_4,
  output logic [1:0]      lamps
);
  // contacts are pushed-pull, so the pins always carry a defined level
  assign digital_input_1 = contacts[0];
  assign digital_input_2 = contacts[1];
  assign digital_input_3 = contacts[2];
  assign digital_input_4 = contacts[3];
  assign lamps           = {digital_output_2, digital_output_1};
endmodule : srvio_switch_model
